// [fetch_pkg.sv]
// Shared constants and carrier types for the background display fetch
`default_nettype none
package fetch_pkg;
	// Register offsets on the 6-bit host port
	localparam logic [5:0] ADDR_MODE_A  = 6'h11;
	localparam logic [5:0] ADDR_MODE_B  = 6'h16;
	localparam logic [5:0] ADDR_MEM_PTR = 6'h18;
	localparam logic [5:0] ADDR_BG0     = 6'h21;
	localparam logic [5:0] ADDR_BG1     = 6'h22;
	localparam logic [5:0] ADDR_BG2     = 6'h23;
	localparam logic [5:0] ADDR_BG3     = 6'h24;
	// Field positions
	localparam int BMM_BIT  = 5;
	localparam int ECM_BIT  = 6;
	localparam int STAT_BIT = 7;
	localparam int MCM_BIT  = 4;
	localparam int VM_LSB   = 4;
	localparam int VM_MSB   = 7;
	localparam int CB_LSB   = 1;
	localparam int CB_MSB   = 3;
	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [3:0] COL_RESET = 4'h0;
	localparam logic [3:0] COL_BLANK = 4'h0;
	// Raster geometry
	localparam logic [5:0] CELL_LAST  = 6'h27;
	localparam logic [9:0] ROW_STEP   = 10'h028;
	localparam logic [2:0] RC_LAST    = 3'h7;
	localparam logic [2:0] IDX_LAST   = 3'h7;
	localparam logic [7:0] LINE_COUNT = 8'hC8;
	localparam logic [7:0] LAST_LINE  = 8'hC7;
	// Dot rate divider, last count of a two-clock dot
	localparam logic [1:0] DIV_LAST   = 2'h1;
	localparam int         FIFO_DEPTH = 4;

	// Background mode bits
	typedef struct packed {
		logic bitmap_select;
		logic extended_background_select;
		logic multicolour_select;
	} mode_s;

	// One video matrix cell, 12 bits wide
	typedef struct packed {
		logic [3:0] colour_nybble_lines;
		logic [7:0] ptr;
	} cell_s;

	// One fetched cell with its dot byte
	typedef struct packed {
		cell_s      matrix;
		logic [7:0] dots;
	} fetch_s;

	// Fetch sequencer states
	typedef enum logic [1:0] {F_IDLE, F_MATRIX, F_GLYPH, F_PUSH} fetch_e;
endpackage : fetch_pkg
`default_nettype wire

// [cell_fifo.sv]
// Small valid/ready FIFO between the fetch sequencer and the dot shifter
`default_nettype none
module cell_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// Filling side
	input  wire logic             in_valid_i,
	output var  logic             in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output var  logic             out_valid_o,
	input  wire logic             out_ready_i,
	output var  logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage words
	logic [AW:0]      wr_ptr;       // Write pointer with wrap bit
	logic [AW:0]      rd_ptr;       // Read pointer with wrap bit
	logic             full;
	logic             empty;

	// Wrap bits differ with equal index only when full
	assign empty       = (wr_ptr == rd_ptr);
	assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
	                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	// Storage write, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	// Pointer updates
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_i && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_ready_i && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : cell_fifo
`default_nettype wire

// [colour_map.sv]
// Dot colour selection for all character and bitmap modes
`default_nettype none
module colour_map
	import fetch_pkg::*;
(
	// Mode and palette
	input  wire mode_s           mode_i,
	input  wire logic [3:0][3:0] bg_i,
	// Current cell and dots
	input  wire cell_s           cell_i,
	input  wire logic            bit_i,
	input  wire logic [1:0]      pair_i,
	// Chosen colour
	output var  logic [3:0]      colour_o
);
	logic [3:0] nyb;   // Colour nybble of the cell
	logic [3:0] hi;    // Upper half of matrix byte
	logic [3:0] lo;    // Lower half of matrix byte
	logic       pairs; // Dots read two at a time

	assign nyb   = cell_i.colour_nybble_lines;
	assign hi    = cell_i.ptr[7:4];
	assign lo    = cell_i.ptr[3:0];
	assign pairs = mode_i.multicolour_select &&
	               (mode_i.bitmap_select || nyb[3]);

	// Colour decision, one branch per mode
	always_comb begin
		colour_o = COL_BLANK;
		// RULE13: illegal combos show blank
		if (mode_i.extended_background_select &&
		    (mode_i.multicolour_select || mode_i.bitmap_select)) begin
			colour_o = COL_BLANK;
		end else if (mode_i.bitmap_select && pairs) begin
			// RULE18: multicolour bitmap pairs
			unique case (pair_i)
				2'b00: colour_o = bg_i[0];
				2'b01: colour_o = hi;
				2'b10: colour_o = lo;
				2'b11: colour_o = nyb;
			endcase
		end else if (mode_i.bitmap_select) begin
			// RULE17: matrix halves, nybble ignored
			colour_o = bit_i ? hi : lo;
		end else if (pairs) begin
			// RULE9: multicolour character pairs
			unique case (pair_i)
				2'b00: colour_o = bg_i[0];
				2'b01: colour_o = bg_i[1];
				2'b10: colour_o = bg_i[2];
				2'b11: colour_o = {1'b0, nyb[2:0]};
			endcase
		end else if (mode_i.multicolour_select) begin
			// RULE8: standard look, low eight colours
			colour_o = bit_i ? {1'b0, nyb[2:0]} : bg_i[0];
		end else if (mode_i.extended_background_select) begin
			// RULE11: pointer top bits pick background
			colour_o = bit_i ? nyb : bg_i[cell_i.ptr[7:6]];
		end else begin
			// RULE7: background 0 or cell nybble
			colour_o = bit_i ? nyb : bg_i[0];
		end
	end
endmodule : colour_map
`default_nettype wire

// [text_bitmap_display_fetch.sv]
// Background display fetch engine: addressing, buffering and dot colour
//
// Notes on behaviour
// RULE1: pointer address is matrix base plus counter
// RULE2: memory address is fourteen bits wide
// RULE3: glyph address is base, pointer, row
// RULE4: eight-bit pointer reaches 256 glyphs
// RULE5: 25 rows of 40 cells
// RULE6: matrix data path is twelve bits
// RULE7: standard mode: background 0 or nybble
// RULE8: multicolour cell with nybble MSB low
// RULE9: multicolour character pairs pick colours
// RULE10: pair dots are twice as wide
// RULE11: extended mode picks background by pointer
// RULE12: extended mode clears glyph bits 10, 9
// RULE13: software avoids extended plus multicolour
// RULE14: bitmap bit maps dots to memory
// RULE15: bitmap address is base, counter, row
// RULE16: counter repeats eight lines, row per line
// RULE17: standard bitmap uses matrix byte halves
// RULE18: multicolour bitmap pair colour table
// RULE19: dot bytes shift out MSB first
// RULE20: counters clear at frame start
`default_nettype none
module text_bitmap_display_fetch
	import fetch_pkg::*;
(
	// Clock and reset
	input  wire logic        REF_CLK_I,
	input  wire logic        SRST_I,
	// Raster timing strobes
	input  wire logic        FRAME_START_I,
	input  wire logic        LINE_START_I,
	// Host register port
	input  wire logic        REG_CS_I,
	input  wire logic        REG_WE_I,
	input  wire logic [5:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	output var  logic [7:0]  REG_RDATA_O,
	// Video memory port
	output var  logic        MEM_REQ_O,
	// RULE2: fourteen-bit address
	output var  logic [13:0] MEM_ADDR_O,
	input  wire logic        MEM_ACK_I,
	input  wire logic [11:0] MEM_DATA_I,
	// Dot output
	output var  logic        DOT_VALID_O,
	output var  logic [3:0]  DOT_COLOUR_O
);
	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]      mode_a;              // Bitmap and extended bits
	logic [7:0]      mode_b;              // Multicolour bit
	logic [7:0]      mem_ptrs;            // Matrix and glyph bases
	logic [3:0][3:0] bg;                  // Background colours 0..3
	mode_s           mode;                // Decoded mode bits
	logic [3:0]      matrix_base_bits;    // Top of pointer address
	logic [2:0]      glyph_base_bits;     // Top of glyph address
	logic [9:0]      matrix_cell_counter; // Cell being fetched
	logic [9:0]      row_base;            // First cell of this row
	logic [2:0]      row_in_cell_counter; // Byte within glyph
	logic [7:0]      line_cnt;            // Display line number
	logic            started;             // A line was begun
	logic            go;                  // Start fetching a line
	logic            disp_active;         // Inside display lines
	logic [5:0]      cell_num;            // Cell within line
	fetch_e          st;                  // Fetch sequencer state
	cell_s           cell_word;           // Captured matrix word
	logic [7:0]      dot_byte;            // Captured dot byte
	logic            glyph_addr_bit10;    // Glyph address bit 10
	logic            glyph_addr_bit9;     // Glyph address bit 9
	logic [13:0]     glyph_addr;          // Character dot address
	logic [13:0]     bitmap_addr;         // Bitmap dot address
	fetch_s          fifo_in;             // Word into buffer
	fetch_s          fifo_out;            // Word out of buffer
	logic            in_valid;
	logic            in_ready;
	logic            out_valid;
	logic            pop;                 // Take next buffered cell
	fetch_s          word;                // Cell on display
	logic [2:0]      idx;                 // Dot within cell
	logic            have;                // Word holds undrawn dots
	logic [1:0]      div;                 // Dot rate divider
	logic            dot_en;              // One pulse per dot
	logic [7:0]      bit_sh;              // Dots aligned for one bit
	logic [7:0]      pair_sh;             // Dots aligned for a pair
	logic [3:0]      map_colour;          // Colour of current dot

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);

	////////////////////////////////////////////////////////////////////////
	// Host registers

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			mode_a   <= REG_RESET;
			mode_b   <= REG_RESET;
			mem_ptrs <= REG_RESET;
			bg       <= '0;
		end else if (REG_CS_I && REG_WE_I) begin
			unique case (REG_ADDR_I)
				ADDR_MODE_A:  mode_a   <= REG_WDATA_I;
				ADDR_MODE_B:  mode_b   <= REG_WDATA_I;
				ADDR_MEM_PTR: mem_ptrs <= REG_WDATA_I;
				ADDR_BG0:     bg[0]    <= REG_WDATA_I[3:0];
				ADDR_BG1:     bg[1]    <= REG_WDATA_I[3:0];
				ADDR_BG2:     bg[2]    <= REG_WDATA_I[3:0];
				ADDR_BG3:     bg[3]    <= REG_WDATA_I[3:0];
				default: ;
			endcase
		end
	end

	// Registered reads; top bit of mode A shows live display state
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			REG_RDATA_O <= REG_RESET;
		end else if (REG_CS_I && !REG_WE_I) begin
			unique case (REG_ADDR_I)
				ADDR_MODE_A: begin
					REG_RDATA_O           <= mode_a;
					REG_RDATA_O[STAT_BIT] <= disp_active;
				end
				ADDR_MODE_B:  REG_RDATA_O <= mode_b;
				ADDR_MEM_PTR: REG_RDATA_O <= mem_ptrs;
				ADDR_BG0:     REG_RDATA_O <= {4'h0, bg[0]};
				ADDR_BG1:     REG_RDATA_O <= {4'h0, bg[1]};
				ADDR_BG2:     REG_RDATA_O <= {4'h0, bg[2]};
				ADDR_BG3:     REG_RDATA_O <= {4'h0, bg[3]};
				default:      REG_RDATA_O <= REG_RESET;
			endcase
		end
	end

	// RULE14: bitmap select steers the fetch
	assign mode.bitmap_select              = mode_a[BMM_BIT];
	assign mode.extended_background_select = mode_a[ECM_BIT];
	assign mode.multicolour_select         = mode_b[MCM_BIT];
	assign matrix_base_bits = mem_ptrs[VM_MSB:VM_LSB];
	assign glyph_base_bits  = mem_ptrs[CB_MSB:CB_LSB];
	assign disp_active      = started && (line_cnt != LINE_COUNT);

	////////////////////////////////////////////////////////////////////////
	// Raster counters

	// Row advances at each new line, cell base every eighth; frame clears them
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I || FRAME_START_I) begin
			// RULE20: clear counters at frame start
			row_base            <= '0;
			row_in_cell_counter <= '0;
			line_cnt            <= '0;
			started             <= 1'b0;
			go                  <= 1'b0;
		end else if (LINE_START_I) begin
			started <= 1'b1;
			// RULE5: only 200 lines are fetched
			go      <= !started || (line_cnt < LAST_LINE);
			if (disp_active) begin
				// RULE16: row per line, base every eighth
				row_in_cell_counter <= row_in_cell_counter + 1'b1;
				line_cnt            <= line_cnt + 1'b1;
				if (row_in_cell_counter == RC_LAST) begin
					row_base <= row_base + ROW_STEP;
				end
			end
		end else begin
			go <= 1'b0;
		end
	end

	// RULE20: frame start clears the counters
	a_frame_clear: assert property (FRAME_START_I |=>  // RULE20
		row_base == '0 && row_in_cell_counter == '0)
		else $error("counters not cleared at frame start");

	// RULE16: base moves by 40 after eighth line
	a_row_step: assert property (                       // RULE16
		LINE_START_I && !FRAME_START_I && disp_active &&
		row_in_cell_counter == RC_LAST
		|=> row_base == $past(row_base) + ROW_STEP &&
		    row_in_cell_counter == '0)
		else $error("row base did not step after eight lines");

	////////////////////////////////////////////////////////////////////////
	// Fetch addressing

	// RULE12: extended mode clears bits 10 and 9
	assign glyph_addr_bit10 = mode.extended_background_select ?
	                          1'b0 : MEM_DATA_I[7];
	assign glyph_addr_bit9  = mode.extended_background_select ?
	                          1'b0 : MEM_DATA_I[6];
	// RULE3: base, pointer, row
	// RULE4: full pointer reaches 256 glyphs
	assign glyph_addr  = {glyph_base_bits, glyph_addr_bit10,
	                      glyph_addr_bit9, MEM_DATA_I[5:0],
	                      row_in_cell_counter};
	// RULE15: top base bit, cell counter, row
	assign bitmap_addr = {glyph_base_bits[2], matrix_cell_counter,
	                      row_in_cell_counter};

	////////////////////////////////////////////////////////////////////////
	// Fetch sequencer

	// Two memory reads per cell, then push into the buffer
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I || FRAME_START_I) begin
			st                  <= F_IDLE;
			MEM_REQ_O           <= 1'b0;
			MEM_ADDR_O          <= '0;
			matrix_cell_counter <= '0;
			cell_num            <= '0;
			cell_word           <= '0;
			dot_byte            <= '0;
		end else begin
			unique case (st)
				// Wait for a display line to begin
				F_IDLE: begin
					if (go) begin
						// RULE1: matrix base over cell counter
						st                  <= F_MATRIX;
						MEM_REQ_O           <= 1'b1;
						MEM_ADDR_O          <= {matrix_base_bits, row_base};
						matrix_cell_counter <= row_base;
						cell_num            <= '0;
					end
				end
				// Pointer and nybble arrive together
				F_MATRIX: begin
					if (MEM_ACK_I) begin
						// RULE6: twelve bit matrix word
						cell_word  <= cell_s'(MEM_DATA_I);
						st         <= F_GLYPH;
						MEM_ADDR_O <= mode.bitmap_select ?
						              bitmap_addr : glyph_addr;
					end
				end
				// Dot byte for this line of the cell
				F_GLYPH: begin
					if (MEM_ACK_I) begin
						dot_byte  <= MEM_DATA_I[7:0];
						MEM_REQ_O <= 1'b0;
						st        <= F_PUSH;
					end
				end
				// Stalls here while the buffer is full
				F_PUSH: begin
					if (in_ready) begin
						// RULE5: forty cells per line
						if (cell_num == CELL_LAST) begin
							st <= F_IDLE;
						end else begin
							st                  <= F_MATRIX;
							MEM_REQ_O           <= 1'b1;
							MEM_ADDR_O          <= {matrix_base_bits,
							                        matrix_cell_counter + 1'b1};
							matrix_cell_counter <= matrix_cell_counter + 1'b1;
							cell_num            <= cell_num + 1'b1;
						end
					end
				end
			endcase
		end
	end

	sequence s_ptr_taken;
		st == F_MATRIX && MEM_ACK_I && !mode.bitmap_select &&
		!mode.extended_background_select;
	endsequence

	sequence s_last_push;
		st == F_PUSH && in_ready && cell_num == CELL_LAST;
	endsequence

	// RULE1: matrix fetch address
	a_matrix_addr: assert property (                     // RULE1
		st == F_MATRIX |->
		MEM_ADDR_O == {matrix_base_bits, matrix_cell_counter})
		else $error("matrix fetch address wrong");

	// RULE2: request holds address until acknowledged
	a_req_hold: assert property (MEM_REQ_O && !MEM_ACK_I  // RULE2
		&& !FRAME_START_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
		else $error("request dropped or address moved before ack");

	// RULE3: glyph fetch follows pointer
	a_fetch_order: assert property (s_ptr_taken |=>      // RULE3
		st == F_GLYPH && MEM_REQ_O &&
		MEM_ADDR_O[10:3] == $past(MEM_DATA_I[7:0]) &&
		MEM_ADDR_O[2:0] == row_in_cell_counter)
		else $error("glyph address not built from pointer");

	// RULE12: glyph bits forced low
	a_ext_zero: assert property (st == F_GLYPH &&         // RULE12
		mode.extended_background_select && !mode.bitmap_select &&
		$past(st) == F_MATRIX |-> MEM_ADDR_O[10:9] == 2'b00)
		else $error("extended mode glyph bits not cleared");

	// RULE15: bitmap dot address
	a_bitmap_addr: assert property (                     // RULE15
		st == F_MATRIX && MEM_ACK_I && mode.bitmap_select |=>
		MEM_ADDR_O == {glyph_base_bits[2], matrix_cell_counter,
		               row_in_cell_counter})
		else $error("bitmap dot address wrong");

	// RULE5: line ends after the fortieth cell
	a_line_cells: assert property (s_last_push |=>        // RULE5
		st == F_IDLE && !MEM_REQ_O)
		else $error("line did not end after forty cells");

	////////////////////////////////////////////////////////////////////////
	// Buffer

	assign fifo_in.matrix = cell_word;
	assign fifo_in.dots   = dot_byte;
	assign in_valid     = (st == F_PUSH);

	cell_fifo #(
		.WIDTH ($bits(fetch_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (REF_CLK_I),
		.srst_i      (SRST_I || FRAME_START_I),
		.in_valid_i  (in_valid),
		.in_ready_o  (in_ready),
		.in_data_i   (fifo_in),
		.out_valid_o (out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Dot shifter

	// Dot rate enable from a free running divider
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			div    <= '0;
			dot_en <= 1'b0;
		end else begin
			dot_en <= (div == DIV_LAST);
			div    <= (div == DIV_LAST) ? 2'h0 : div + 1'b1;
		end
	end

	// Next cell is taken when the last dot of this one is drawn
	assign pop = out_valid && (!have || (dot_en && idx == IDX_LAST));

	// Word and dot index; empty buffer simply leaves a gap
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I || FRAME_START_I) begin
			word <= '0;
			idx  <= '0;
			have <= 1'b0;
		end else if (pop) begin
			word <= fifo_out;
			idx  <= '0;
			have <= 1'b1;
		end else if (dot_en && have) begin
			idx <= idx + 1'b1;
			if (idx == IDX_LAST) begin
				have <= 1'b0;
			end
		end
	end

	// RULE19: bit 7 is the leftmost dot
	assign bit_sh  = word.dots << idx;
	// RULE10: one pair held for two dots
	assign pair_sh = word.dots << {idx[2:1], 1'b0};

	colour_map u_map (
		.mode_i   (mode),
		.bg_i     (bg),
		.cell_i   (word.matrix),
		.bit_i    (bit_sh[7]),
		.pair_i   (pair_sh[7:6]),
		.colour_o (map_colour)
	);

	// Registered dot outputs, one valid pulse per drawn dot
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			DOT_VALID_O  <= 1'b0;
			DOT_COLOUR_O <= COL_RESET;
		end else begin
			DOT_VALID_O <= dot_en && have;
			if (dot_en && have) begin
				DOT_COLOUR_O <= map_colour;
			end
		end
	end

	// RULE19: first dot is byte bit 7
	a_msb_first: assert property (pop && !FRAME_START_I   // RULE19
		|=> idx == '0 && bit_sh[7] == $past(fifo_out.dots[7]))
		else $error("first dot is not the byte MSB");

	// RULE7: standard mode dot colour
	a_std_dot: assert property (dot_en && have &&         // RULE7
		mode == '0 |=> DOT_VALID_O && DOT_COLOUR_O ==
		($past(bit_sh[7]) ? $past(word.matrix.colour_nybble_lines)
		                  : $past(bg[0])))
		else $error("standard mode colour wrong");
endmodule : text_bitmap_display_fetch
`default_nettype wire

// [vmem_model.sv]
// Behavioural video memory that answers the fetch engine
`default_nettype none
module vmem_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Request side
	input  wire logic        req_i,
	input  wire logic [13:0] addr_i,
	input  wire logic        slow_i,
	// Answer side
	output logic             ack_o,
	output logic [11:0]      data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_cnt; // Idle cycles on this request
	////////////////////////////////////////////////////////////////////
	// Contents: nybble and rotated low address byte, so every cell of a line differs
	function automatic logic [11:0] word(input logic [13:0] a);
		return {a[3:0] ^ a[7:4], {a[1:0], a[7:2]} ^ 8'h35};
	endfunction : word
	// twelve-bit answer
	// Ack after zero or three waits; idle lines flip, never hold
	always @(posedge clk_i) begin
		if (srst_i) begin
			ack_o    <= 1'b0;
			wait_cnt <= 2'h0;
			data_o   <= 12'h000;
		end else if (!req_i || ack_o) begin
			ack_o    <= 1'b0;
			wait_cnt <= 2'h0;
			data_o   <= ~data_o;
		end else if (!slow_i || wait_cnt == 2'h3) begin
			ack_o  <= 1'b1;
			data_o <= word(addr_i);
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
			data_o   <= ~data_o;
		end
	end
endmodule : vmem_model
`default_nettype wire

// [tb_text_bitmap_display_fetch.sv]
// Self-checking bench for the background display fetch engine
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_text_bitmap_display_fetch
	import fetch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, fs = 1'b0, ls = 1'b0;
	logic        cs = 1'b0, we = 1'b0, slow = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic [7:0]  wd = 8'h00, rd;
	logic        req, ack, dv;
	logic [13:0] maddr;
	logic [11:0] mdata;
	logic [3:0]  dc;
	logic [3:0]  bgc [4];  // Palette mirror
	logic [7:0]  ptrs;     // Memory base value
	mode_s       mode;     // Mode in force
	int          miscompares = 0, compares = 0;
	logic [13:0] aq [$];   // Acked addresses
	logic [3:0]  cq [$];   // Drawn colours
	logic [5:0]  regs [7] = '{ADDR_MODE_A, ADDR_MODE_B, ADDR_MEM_PTR,
		ADDR_BG0, ADDR_BG1, ADDR_BG2, ADDR_BG3};
	always #20 clk = ~clk;
	text_bitmap_display_fetch text_bitmap_display_fetch_i (
		.REF_CLK_I(clk), .SRST_I(srst), .FRAME_START_I(fs),
		.LINE_START_I(ls), .REG_CS_I(cs), .REG_WE_I(we),
		.REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rd),
		.MEM_REQ_O(req), .MEM_ADDR_O(maddr), .MEM_ACK_I(ack),
		.MEM_DATA_I(mdata), .DOT_VALID_O(dv), .DOT_COLOUR_O(dc));
	vmem_model vmem_model_i (.clk_i(clk), .srst_i(srst), .req_i(req),
		.addr_i(maddr), .slow_i(slow), .ack_o(ack), .data_o(mdata));
	////////////////////////////////////////////////////////////////////
	// Capture taken fetches and drawn dots
	always @(posedge clk) begin
		if (req && ack) aq.push_back(maddr);
		if (dv) cq.push_back(dc);
	end
	// Same contents as the memory model
	function automatic logic [11:0] word(input logic [13:0] a);
		return {a[3:0] ^ a[7:4], {a[1:0], a[7:2]} ^ 8'h35};
	endfunction : word
	// Expected colour of dot k of a cell
	function automatic logic [3:0] col(input cell_s c, input logic [7:0] d,
		input int k);
		logic       b;
		logic [1:0] pr;
		logic [3:0] n;
		b  = d[7-k];
		pr = {d[7-(k&6)], d[6-(k&6)]};
		n  = c.colour_nybble_lines;
		case (mode)
			3'b001: begin
				if (!n[3]) return b ? {1'b0, n[2:0]} : bgc[0];
				return (pr == 2'h3) ? {1'b0, n[2:0]} : bgc[pr];
			end
			3'b010: return b ? n : bgc[c.ptr[7:6]];
			3'b100: return b ? c.ptr[7:4] : c.ptr[3:0];
			3'b101: begin
				case (pr)
					2'h0: return bgc[0];
					2'h1: return c.ptr[7:4];
					2'h2: return c.ptr[3:0];
					default: return n;
				endcase
			end
			default: return b ? n : bgc[0];
		endcase
	endfunction : col
	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		{cs, we, addr, wd} = {2'b11, a, d};
		@(negedge clk);
		{cs, we} = 2'b00;
	endtask : wr
	// Read, data checked half a cycle after the taking edge
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		@(negedge clk);
		{cs, we, addr} = {2'b10, a};
		@(negedge clk);
		cs = 1'b0;
		`CHK("reg", e, rd)
	endtask : rdchk
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	// One raster line: every fetch address and every dot colour
	task automatic line_chk(input int l);
		cell_s       c;
		logic [9:0]  vc;
		logic [2:0]  rc;
		logic [13:0] ga;
		logic [7:0]  d;
		rc = 3'(l % 8);
		aq = {};
		cq = {};
		pulse(ls);
		for (int t = 0; t < 1500 && cq.size() < 320; t++) @(negedge clk);
		`CHK("fetches", 80, aq.size())
		`CHK("dots", 320, cq.size())
		for (int i = 0; i < 40 && cq.size() == 320; i++) begin
			vc = 10'((l / 8) * 40 + i);
			c  = word({ptrs[7:4], vc});
			ga = mode.bitmap_select ? {ptrs[3], vc, rc} : {ptrs[3:1],
				mode.extended_background_select ? {2'b00, c.ptr[5:0]}
				: c.ptr, rc};
			d  = 8'(word(ga));
			`CHK("mat_addr", {ptrs[7:4], vc}, aq[2*i])
			`CHK("dot_addr", ga, aq[2*i+1])
			for (int k = 0; k < 8; k++)
				`CHK("colour", col(c, d, k), cq[8*i+k])
		end
	endtask : line_chk
	// bench never mixes extended and multicolour
	task automatic frame(input mode_s m, input logic [7:0] p, input int n);
		mode = m;
		ptrs = p;
		wr(ADDR_MODE_A, {1'b0, m[1], m[2], 5'h00});
		wr(ADDR_MODE_B, {3'h0, m[0], 4'h0});
		wr(ADDR_MEM_PTR, p);
		pulse(fs);
		for (int l = 0; l < n; l++) line_chk(l);
		$display("test mode %b done", m);
	endtask : frame
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////
	// Hang guard, well past the 16 lines of traffic
	initial begin
		#2000000;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		foreach (regs[i]) rdchk(regs[i], REG_RESET);
		wr(6'h3F, 8'hFF);
		rdchk(6'h3F, 8'h00);
		wr(ADDR_MODE_A, 8'h80);
		rdchk(ADDR_MODE_A, 8'h00);
		for (int i = 0; i < 4; i++) begin
			bgc[i] = 4'(4'h9 + i);
			wr(6'(ADDR_BG0 + i), {4'hF, bgc[i]});
			rdchk(6'(ADDR_BG0 + i), {4'h0, bgc[i]});
		end
		$display("test registers done");
		// Slow memory, nine lines cross a cell row
		slow = 1'b1;
		frame(3'b000, 8'h3A, 9);
		slow = 1'b0;
		frame(3'b001, 8'hC6, 2);
		frame(3'b010, 8'h74, 2);
		frame(3'b100, 8'h5C, 2);
		frame(3'b101, 8'hE8, 1);
		// Bitmap bit kept, top bit shows display active
		rdchk(ADDR_MODE_A, 8'hA0);
		print_verdict();
	end
endmodule : tb_text_bitmap_display_fetch
`default_nettype wire
